// ---- hdl/tmh_cfg.svh ----
// register map, field positions, reset values and divider constants of the timer
`ifndef TMH_CFG_SVH
`define TMH_CFG_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define TMH_ADDR_MODE      16'hff70
`define TMH_ADDR_DIR       16'hff24
`define TMH_ADDR_PERIOD    16'hff71
`define TMH_ADDR_DUTY      16'hff72
`define TMH_ADDR_COUNT     16'hff73
`define TMH_ADDR_LATCH     16'hff04

// ---------------------------------------------------------------
// mode control fields
// ---------------------------------------------------------------
`define TMH_BIT_EN         7
`define TMH_CKS_HI         6
`define TMH_CKS_LO         4
`define TMH_MD_HI          3
`define TMH_MD_LO          2
`define TMH_BIT_LEV        1
`define TMH_BIT_OEN        0
`define TMH_TIMER_PIN      2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TMH_RST_MODE       8'h00
`define TMH_RST_DIR        8'hff
`define TMH_RST_CMP        8'h00
`define TMH_RST_LATCH      8'h00
`define TMH_DIR_FIXED      8'hc0

// ---------------------------------------------------------------
// count clock dividers and duty transfer delay
// ---------------------------------------------------------------
`define TMH_DIV4_LAST      12'h003
`define TMH_DIV16_LAST     12'h00f
`define TMH_DIV64_LAST     12'h03f
`define TMH_DIV4096_LAST   12'hfff
`define TMH_RING_LAST      7'h7f
`define TMH_DUTY_DELAY     2'h3

`endif

// ---- hdl/tmh_pkg.sv ----
// types shared by the timer modules
package tmh_pkg;

  typedef enum logic [2:0] {
    TMH_CK_DIV1    = 3'h0,
    TMH_CK_DIV4    = 3'h1,
    TMH_CK_DIV16   = 3'h2,
    TMH_CK_DIV64   = 3'h3,
    TMH_CK_DIV4096 = 3'h4,
    TMH_CK_RING    = 3'h5
  } tmh_cks_t;

  typedef enum logic [1:0] {
    TMH_MD_INTERVAL = 2'h0,
    TMH_MD_PWM      = 2'h2
  } tmh_mode_t;

  typedef enum logic {
    TMH_CMP_PERIOD,
    TMH_CMP_DUTY
  } tmh_cmp_t;

endpackage

// ---- hdl/tmh_tick_if.sv ----
// count clock request and tick between timer core and prescaler
interface tmh_tick_if;
  logic [2:0] clk_sel;
  logic       tick;

  modport core (
    output clk_sel,
    input  tick
  );

  modport presc (
    input  clk_sel,
    output tick
  );
endinterface

// ---- hdl/tmh_prescaler.sv ----
// count clock prescaler: divided peripheral clock or divided slow ring clock
`include "tmh_cfg.svh"

module tmh_prescaler (
  input  wire logic  mclk,
  input  wire logic  nrst,
  input  wire logic  ring_osc,
  tmh_tick_if.presc  tk
);

  logic [11:0] div_r;
  logic [6:0]  ring_div_r;
  logic        ring_d_r;
  logic        ring_edge;
  logic        tick_r;
  logic        tick_nxt;

  assign ring_edge = ring_osc & ~ring_d_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 12'h000;
    end else begin
      div_r <= div_r + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ring_d_r   <= 1'b0;
      ring_div_r <= 7'h00;
    end else begin
      ring_d_r <= ring_osc;
      if (ring_edge) begin
        ring_div_r <= ring_div_r + 7'h01;
      end
    end
  end

  always_comb begin
    unique case (tk.clk_sel)
      tmh_pkg::TMH_CK_DIV1:    tick_nxt = 1'b1;
      tmh_pkg::TMH_CK_DIV4:    tick_nxt = (div_r[1:0] == `TMH_DIV4_LAST);
      tmh_pkg::TMH_CK_DIV16:   tick_nxt = (div_r[3:0] == `TMH_DIV16_LAST);
      tmh_pkg::TMH_CK_DIV64:   tick_nxt = (div_r[5:0] == `TMH_DIV64_LAST);
      tmh_pkg::TMH_CK_DIV4096: tick_nxt = (div_r == `TMH_DIV4096_LAST);
      tmh_pkg::TMH_CK_RING:    tick_nxt = ring_edge && (ring_div_r == `TMH_RING_LAST);
      default:                 tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  assign tk.tick = tick_r;

  a_div4_spacing: assert property (@(posedge mclk) disable iff (!nrst)
    ((tk.clk_sel == 3'h1)[*5] ##0 tk.tick) |=> (!tk.tick)[*3])
    else $error("divide-by-4 tick spacing wrong");

endmodule

// ---- hdl/tmh_timer.sv ----
// 8-bit interval / pwm timer with its mode, compare and port registers
//
// Summary of operation
// - enable bit low keeps counter at zero and stopped; high lets it count
// - clock select picks fxp, /4, /16, /64, /4096 or ring/128
// - mode field 00 selects interval, 10 selects pwm
// - default level bit sets inactive output level
// - output enable gates output to pin; interval gives 50% square wave
// - reset clears mode register; bit and byte writes accepted
// - interval match on period raises interrupt and clears counter
// - interval mode ignores the duty compare register
// - interval interrupt repeats every period plus one count clocks
// - interval counting begins within one count clock after enabling; pwm within two
// - interval match toggles output, clears counter, raises interrupt
// - disabling forces interrupt and output inactive
// - duty register is writable while counting
// - pwm period match clears counter, interrupts, activates output, selects duty
// - pwm duty match deactivates output, reselects period, no clear, no interrupt
// - pwm period is N+1 count clocks, active width M+1
// - new duty needs three count clocks before it can transfer
// - running duty write buffered, loaded at old duty match, skipped on cpu write
// - pwm start masks first count clock, output stays inactive
`include "tmh_cfg.svh"

module tmh_timer (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ring_osc,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_bit_wr,
  input  wire logic [2:0]  cpu_bit_sel,
  input  wire logic        cpu_bit_val,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_rd,
  output logic      [7:0]  cpu_rdata,
  input  wire logic [7:0]  port4_in,
  output logic      [7:0]  port4_out,
  output logic      [7:0]  port4_oe,
  output logic             match_interrupt
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]           mode_r;
  logic [7:0]           dir_r;
  logic [7:0]           latch_r;
  logic [7:0]           period_r;
  logic [7:0]           duty_buf_r;
  logic [7:0]           duty_act_r;
  logic                 duty_pend_r;
  logic [1:0]           duty_age_r;
  logic [7:0]           cnt_r;
  logic                 act_r;
  logic                 irq_r;
  logic                 first_r;
  tmh_pkg::tmh_cmp_t    cmp_r;
  logic [7:0]           rdata_r;

  logic                 en;
  logic                 pwm;
  logic                 lev;
  logic                 oen;
  logic                 tick;
  logic                 step;
  logic [7:0]           cmp_val;
  logic                 hit;
  logic                 duty_wr;
  logic                 xfer;
  logic                 timer_out;

  tmh_tick_if tk ();

  tmh_prescaler u_presc (
    .mclk     (mclk),
    .nrst     (nrst),
    .ring_osc (ring_osc),
    .tk       (tk.presc)
  );

  assign en   = mode_r[`TMH_BIT_EN];
  assign pwm  = (mode_r[`TMH_MD_HI:`TMH_MD_LO] == tmh_pkg::TMH_MD_PWM);
  assign lev  = mode_r[`TMH_BIT_LEV];
  assign oen  = mode_r[`TMH_BIT_OEN];
  assign tk.clk_sel = mode_r[`TMH_CKS_HI:`TMH_CKS_LO];
  assign tick = tk.tick;

  // ---------------------------------------------------------------
  // cpu writes
  // ---------------------------------------------------------------
  function automatic logic [7:0] wr_val(input logic [7:0] old);
    logic [7:0] v;
    v = old;
    if (cpu_bit_wr) begin
      v[cpu_bit_sel] = cpu_bit_val;
    end else begin
      v = cpu_wdata;
    end
    return v;
  endfunction

  function automatic logic hit_addr(input logic [15:0] a);
    return (cpu_wr || cpu_bit_wr) && (cpu_addr == a);
  endfunction

  assign duty_wr = (cpu_wr || cpu_bit_wr) && (cpu_addr == `TMH_ADDR_DUTY);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= `TMH_RST_MODE;
    end else if (hit_addr(`TMH_ADDR_MODE)) begin
      mode_r <= wr_val(mode_r);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_r   <= `TMH_RST_DIR;
      latch_r <= `TMH_RST_LATCH;
    end else begin
      if (hit_addr(`TMH_ADDR_DIR)) begin
        dir_r <= wr_val(dir_r) | `TMH_DIR_FIXED;
      end
      if (hit_addr(`TMH_ADDR_LATCH)) begin
        latch_r <= wr_val(latch_r);
      end
    end
  end

  // period is taken whenever written; stopping first is software's duty
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      period_r <= `TMH_RST_CMP;
    end else if (hit_addr(`TMH_ADDR_PERIOD)) begin
      period_r <= wr_val(period_r);
    end
  end

  // ---------------------------------------------------------------
  // duty buffer and transfer
  // ---------------------------------------------------------------
  assign xfer = en && pwm && step && (cmp_r == tmh_pkg::TMH_CMP_DUTY) && hit
                && duty_pend_r && (duty_age_r == `TMH_DUTY_DELAY) && !duty_wr;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      duty_buf_r <= `TMH_RST_CMP;
    end else if (duty_wr) begin
      duty_buf_r <= wr_val(duty_buf_r);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      duty_pend_r <= 1'b0;
      duty_age_r  <= 2'h0;
    end else if (duty_wr) begin
      duty_pend_r <= 1'b1;
      duty_age_r  <= 2'h0;
    end else if (!en || xfer) begin
      duty_pend_r <= 1'b0;
      duty_age_r  <= 2'h0;
    end else if (tick && duty_age_r != `TMH_DUTY_DELAY) begin
      duty_age_r <= duty_age_r + 2'h1;
    end
  end

  // while stopped the active compare follows the buffer, ready for restart
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      duty_act_r <= `TMH_RST_CMP;
    end else if (!en) begin
      duty_act_r <= duty_buf_r;
    end else if (xfer) begin
      duty_act_r <= duty_buf_r;
    end
  end

  // ---------------------------------------------------------------
  // counter and compare sequencing
  // ---------------------------------------------------------------
  assign cmp_val = (cmp_r == tmh_pkg::TMH_CMP_DUTY) ? duty_act_r : period_r;
  assign hit     = (cnt_r == cmp_val);
  assign step    = tick && !(pwm && first_r);

  // held high while stopped so the first tick after a pwm start is dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      first_r <= 1'b1;
    end else if (!en) begin
      first_r <= 1'b1;
    end else if (tick) begin
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
    end else if (!en) begin
      cnt_r <= 8'h00;
    end else if (step) begin
      if (hit && cmp_r == tmh_pkg::TMH_CMP_PERIOD) begin
        cnt_r <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_r <= tmh_pkg::TMH_CMP_PERIOD;
    end else if (!en || !pwm) begin
      cmp_r <= tmh_pkg::TMH_CMP_PERIOD;
    end else if (step && hit) begin
      unique case (cmp_r)
        tmh_pkg::TMH_CMP_PERIOD: cmp_r <= tmh_pkg::TMH_CMP_DUTY;
        tmh_pkg::TMH_CMP_DUTY:   cmp_r <= tmh_pkg::TMH_CMP_PERIOD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      act_r <= 1'b0;
    end else if (!en) begin
      act_r <= 1'b0;
    end else if (step && hit) begin
      if (!pwm) begin
        act_r <= !act_r;
      end else if (cmp_r == tmh_pkg::TMH_CMP_PERIOD) begin
        act_r <= 1'b1;
      end else begin
        act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= en && step && hit && cmp_r == tmh_pkg::TMH_CMP_PERIOD;
    end
  end

  assign match_interrupt = irq_r;

  // ---------------------------------------------------------------
  // output and port pins
  // ---------------------------------------------------------------
  assign timer_out = oen ? (act_r ^ lev) : lev;

  always_comb begin
    port4_out = latch_r;
    port4_out[`TMH_TIMER_PIN] = latch_r[`TMH_TIMER_PIN] | timer_out;
    port4_oe  = ~dir_r;
  end

  // ---------------------------------------------------------------
  // cpu reads
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (cpu_rd) begin
      unique case (cpu_addr)
        `TMH_ADDR_MODE:   rdata_r <= mode_r;
        `TMH_ADDR_DIR:    rdata_r <= dir_r;
        `TMH_ADDR_PERIOD: rdata_r <= period_r;
        `TMH_ADDR_DUTY:   rdata_r <= duty_buf_r;
        `TMH_ADDR_COUNT:  rdata_r <= cnt_r;
        `TMH_ADDR_LATCH:  rdata_r <= (port4_in & dir_r) | (latch_r & ~dir_r);
        default:          rdata_r <= 8'h00;
      endcase
    end
  end

  assign cpu_rdata = rdata_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_stop_clears: assert property (@(posedge mclk) disable iff (!nrst)
    !en |=> (cnt_r == 8'h00))
    else $error("counter not cleared while stopped");

  a_stop_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    (!en && !$past(en)) |-> (!match_interrupt && timer_out == lev))
    else $error("output or interrupt active while stopped");

  a_interval_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    (en && !pwm && step && cnt_r == period_r) |=> (cnt_r == 8'h00 && match_interrupt))
    else $error("interval match did not clear and interrupt");

  a_interval_toggle: assert property (@(posedge mclk) disable iff (!nrst)
    (en && !pwm && step && cnt_r == period_r && $stable(mode_r)) |=> (act_r != $past(act_r)))
    else $error("interval match did not toggle output");

  a_interval_period: assert property (@(posedge mclk) disable iff (!nrst)
    (en && !pwm) |-> (cmp_r == tmh_pkg::TMH_CMP_PERIOD))
    else $error("duty compare used in interval mode");

  a_duty_no_clear: assert property (@(posedge mclk) disable iff (!nrst)
    (en && pwm && step && hit && cmp_r == tmh_pkg::TMH_CMP_DUTY)
    |=> (cnt_r == $past(cnt_r) + 8'h01 && !match_interrupt && !act_r))
    else $error("duty match cleared counter or interrupted");

  a_pwm_start_mask: assert property (@(posedge mclk) disable iff (!nrst)
    (en && pwm && first_r && tick) |=> (cnt_r == 8'h00 && !act_r))
    else $error("first count clock not masked");

  a_duty_delay: assert property (@(posedge mclk) disable iff (!nrst)
    xfer |-> (!duty_wr && !$past(duty_wr) && !$past(duty_wr, 2)
              && !$past(duty_wr, 3)))
    else $error("duty transferred too early");

  a_out_gate: assert property (@(posedge mclk) disable iff (!nrst)
    !oen |-> (timer_out == lev))
    else $error("output not gated by enable bit");

  a_pwm_period_hit: assert property (@(posedge mclk) disable iff (!nrst)
    (en && pwm && step && hit && cmp_r == tmh_pkg::TMH_CMP_PERIOD)
    |=> (cnt_r == 8'h00 && match_interrupt && act_r && cmp_r == tmh_pkg::TMH_CMP_DUTY))
    else $error("pwm period match sequence wrong");

  a_disable_quiet: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(en) |=> (!match_interrupt && timer_out == lev))
    else $error("disable did not force inactive state");

  a_duty_accept: assert property (@(posedge mclk) disable iff (!nrst)
    (en && pwm && duty_wr && !cpu_bit_wr) |=> (duty_buf_r == $past(cpu_wdata)))
    else $error("running duty write not accepted");

endmodule

// ---- verification/tmh_pin_load.sv ----
// far side model: pin load with floating inputs and slow ring oscillator
module tmh_pin_load #(
  parameter int RING_HALF = 4
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [7:0] port4_out,
  input  wire logic [7:0] port4_oe,
  output logic      [7:0] port4_in,
  output logic            ring_osc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       flip_r;
  logic [7:0] ring_cnt_r;

  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  // undriven pins flip every cycle so a stale value never reads back
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flip_r <= 1'b0;
    end else begin
      flip_r <= ~flip_r;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port4_in[i] = port4_oe[i] ? port4_out[i] : flip_r;
    end
  end

  // ---------------------------------------------------------------
  // ring oscillator
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ring_cnt_r <= 8'h00;
      ring_osc   <= 1'b0;
    end else if (ring_cnt_r == 8'(RING_HALF - 1)) begin
      ring_cnt_r <= 8'h00;
      ring_osc   <= ~ring_osc;
    end else begin
      ring_cnt_r <= ring_cnt_r + 8'h01;
    end
  end
endmodule

// ---- verification/interval_pwm_timer8_tb_top.sv ----
// register level testbench of the interval / pwm timer
`include "tmh_cfg.svh"

module interval_pwm_timer8_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RING_HALF = 4;
  localparam int LIMIT     = 20000;

  logic        mclk;
  logic        nrst;
  logic        ring_osc;
  logic [15:0] cpu_addr;
  logic        cpu_wr;
  logic        cpu_bit_wr;
  logic [2:0]  cpu_bit_sel;
  logic        cpu_bit_val;
  logic [7:0]  cpu_wdata;
  logic        cpu_rd;
  logic [7:0]  cpu_rdata;
  logic [7:0]  port4_in;
  logic [7:0]  port4_out;
  logic [7:0]  port4_oe;
  logic        match_interrupt;
  int          miscompares;
  int          comparisons;

  tmh_timer dut_u (
    .mclk            (mclk),
    .nrst            (nrst),
    .ring_osc        (ring_osc),
    .cpu_addr        (cpu_addr),
    .cpu_wr          (cpu_wr),
    .cpu_bit_wr      (cpu_bit_wr),
    .cpu_bit_sel     (cpu_bit_sel),
    .cpu_bit_val     (cpu_bit_val),
    .cpu_wdata       (cpu_wdata),
    .cpu_rd          (cpu_rd),
    .cpu_rdata       (cpu_rdata),
    .port4_in        (port4_in),
    .port4_out       (port4_out),
    .port4_oe        (port4_oe),
    .match_interrupt (match_interrupt)
  );

  tmh_pin_load #(.RING_HALF(RING_HALF)) load_u (
    .mclk      (mclk),
    .nrst      (nrst),
    .port4_out (port4_out),
    .port4_oe  (port4_oe),
    .port4_in  (port4_in),
    .ring_osc  (ring_osc)
  );

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge mclk);
    cpu_wr    <= 1'b0;
  endtask

  task automatic bwr(input logic [15:0] a, input logic [2:0] s, input logic v);
    @(posedge mclk);
    cpu_addr    <= a;
    cpu_bit_sel <= s;
    cpu_bit_val <= v;
    cpu_bit_wr  <= 1'b1;
    @(posedge mclk);
    cpu_bit_wr  <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge mclk);
    cpu_rd   <= 1'b0;
    @(negedge mclk);
    d = cpu_rdata;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic rdchk(input string n, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask

  // stop, configure, then start; duty written at every start
  task automatic run(input logic [2:0] cks, input logic [1:0] md, input logic lev,
                     input logic [7:0] n, input logic [7:0] m);
    wr(`TMH_ADDR_MODE, {1'b0, cks, md, lev, 1'b1});
    wr(`TMH_ADDR_PERIOD, n);
    wr(`TMH_ADDR_DUTY, m);
    wr(`TMH_ADDR_MODE, {1'b1, cks, md, lev, 1'b1});
  endtask

  // waits for an interrupt (one showing at a negedge call counts), measures up to the next
  task automatic measure(input logic act, output logic [15:0] k, output logic [15:0] gap,
                         output logic [15:0] w);
    k = 16'h0000;
    if (mclk !== 1'b0) begin
      @(negedge mclk);
    end
    while (match_interrupt !== 1'b1 && k < 16'(LIMIT)) begin
      @(negedge mclk);
      k++;
    end
    gap = 16'h0001;
    w   = {15'h0000, port4_out[2] === act};
    @(negedge mclk);
    while (match_interrupt !== 1'b1 && gap < 16'(LIMIT)) begin
      gap++;
      w = w + {15'h0000, port4_out[2] === act};
      @(negedge mclk);
    end
  endtask

  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, reset and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] k;
    logic [15:0] g;
    logic [15:0] w;
    logic [15:0] w2;
    logic [15:0] divs [6];
    logic [7:0]  pw [3][3];
    miscompares = 0;
    comparisons = 0;
    divs = '{16'h0001, 16'h0004, 16'h0010, 16'h0040, 16'h1000, 16'(128 * 2 * RING_HALF)};
    pw   = '{'{8'h00, 8'h04, 8'h01}, '{8'h01, 8'h01, 8'h00}, '{8'h00, 8'hff, 8'hfe}};
    nrst = 1'b0;
    cpu_addr = 16'h0000;
    cpu_wr = 1'b0;
    cpu_bit_wr = 1'b0;
    cpu_bit_sel = 3'h0;
    cpu_bit_val = 1'b0;
    cpu_wdata = 8'h00;
    cpu_rd = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    rdchk("mode reset", `TMH_ADDR_MODE, `TMH_RST_MODE);
    rdchk("dir reset", `TMH_ADDR_DIR, 8'hff);
    chk("oe reset", 16'h0000, {8'h00, port4_oe});
    wr(`TMH_ADDR_DIR, 8'h00);
    wr(`TMH_ADDR_LATCH, 8'h00);
    rdchk("dir fixed", `TMH_ADDR_DIR, `TMH_DIR_FIXED);
    chk("oe routed", 16'h003f, {8'h00, port4_oe});
    bwr(`TMH_ADDR_MODE, 3'h1, 1'b1);
    rdchk("bit write", `TMH_ADDR_MODE, 8'h02);
    bwr(`TMH_ADDR_MODE, 3'h0, 1'b1);
    rdchk("bit write 2", `TMH_ADDR_MODE, 8'h03);
    chk("idle high", 16'h0001, {15'h0000, port4_out[2]});
    wr(16'hff99, 8'h55);
    rdchk("unmapped", 16'hff99, 8'h00);
    rdchk("stopped count", `TMH_ADDR_COUNT, 8'h00);
    // interval, inactive high, active low
    run(3'h0, 2'(tmh_pkg::TMH_MD_INTERVAL), 1'b1, 8'h02, 8'h01);
    measure(1'b0, k, g, w);
    chk("start delay", 16'h0001, {15'h0000, k <= 16'h0004});
    chk("interval gap", 16'h0003, g);
    measure(1'b0, k, g, w2);
    chk("square wave", 16'h0003, w + w2);
    wr(`TMH_ADDR_DUTY, 8'h00);
    measure(1'b0, k, g, w);
    measure(1'b0, k, g, w);
    chk("duty ignored", 16'h0003, g);
    wr(`TMH_ADDR_MODE, 8'h03);
    repeat (4) @(negedge mclk);
    chk("stop irq", 16'h0000, {15'h0000, match_interrupt});
    chk("stop pin", 16'h0001, {15'h0000, port4_out[2]});
    rdchk("cleared count", `TMH_ADDR_COUNT, 8'h00);
    wr(`TMH_ADDR_MODE, 8'h02);
    wr(`TMH_ADDR_MODE, 8'h82);
    measure(1'b0, k, g, w);
    chk("out gated", 16'h0000, w);
    wr(`TMH_ADDR_MODE, 8'h02);
    for (int c = 0; c < 6; c++) begin
      run(3'(c), 2'(tmh_pkg::TMH_MD_INTERVAL), 1'b0, 8'h01, 8'h00);
      measure(1'b1, k, g, w);
      chk("count clock", 16'(2 * divs[c]), g);
    end
    for (int p = 0; p < 3; p++) begin
      run(3'h0, 2'(tmh_pkg::TMH_MD_PWM), pw[p][0][0], pw[p][1], pw[p][2]);
      @(negedge mclk);
      chk("pwm start", {15'h0000, pw[p][0][0]}, {15'h0000, port4_out[2]});
      measure(~pw[p][0][0], k, g, w);
      measure(~pw[p][0][0], k, g, w);
      chk("pwm period", 16'(pw[p][1]) + 16'h0001, g);
      chk("pwm width", 16'(pw[p][2]) + 16'h0001, w);
      if (p == 0) begin
        wr(`TMH_ADDR_DUTY, 8'h03);
        for (int i = 0; i < 3; i++) begin
          measure(1'b1, k, g, w);
        end
        chk("new duty", 16'h0004, w);
      end
      wr(`TMH_ADDR_MODE, {6'h00, pw[p][0][0], 1'b0} | 8'h09);
      repeat (3) @(negedge mclk);
      chk("pwm stop", {15'h0000, pw[p][0][0]}, {15'h0000, port4_out[2]});
    end
    complete_run();
  end
endmodule
